/* File: inc/pdx_consts.svh */
// Constants for the clock generator configuration block: register
// offsets, field positions, reset contents and crosspoint codes.
// Assumes 8-bit register addresses and 8-bit register data.
//
// Summary of operation
// - Load capacitance code is one 8-bit register, 0.09375 pF per step.
// - Load capacitance code defaults to zero for an external reference.
// - Pre-divide total is the predivider register bits 6..0 plus two.
// - Multiplier total is twice (base plus four) plus the odd bit.
// - Top three bits of the pump register read 1,1,0, ignore writes.
// - Base 0 odd 0 gives 8; base 1023 odd 1 gives maximum.
// - VCO equals reference over pre-divide total times multiplier total.
// - Each divider bank has its own VCO or reference source mux.
// - Bank registers hold source select in bit 7, divisor in 6..0.
// - Banks offer /2, /3, /4 and /N; host keeps N in 4..127.
// - Six outputs pick one of seven sources via 3-bit fields.
// - Bank 1 /2 aligns with /N for N mod 4; /3 for N six.
// - Bank 2 /2 aligns for N mod 4; /4 aligns for N mod 8.
// - Codes: ref, b1 /N, b1 /2, b1 /3, b2 /N, b2 /2, b2 /4; 111 reserved.
`ifndef PDX_CONSTS_SVH
`define PDX_CONSTS_SVH

`define PDX_ADDR_BANK1      8'h0C
`define PDX_ADDR_DRIVE      8'h12
`define PDX_ADDR_LOADCAP    8'h13
`define PDX_ADDR_PUMP_FBH   8'h40
`define PDX_ADDR_FB_LOW     8'h41
`define PDX_ADDR_ODD_PRE    8'h42
`define PDX_ADDR_XP0        8'h44
`define PDX_ADDR_XP1        8'h45
`define PDX_ADDR_XP2        8'h46
`define PDX_ADDR_BANK2      8'h47

`define PDX_SRC_BIT         7
`define PDX_ODD_BIT         7
`define PDX_PUMP_LSB        2
`define PDX_DRV_LSB         3
`define PDX_XP2_LSB         6

`define PDX_R40_FIXED       3'b110
`define PDX_R46_FIXED       6'h3F
`define PDX_R12_HIGH        3'b001
`define PDX_R12_LOW         3'b000

`define PDX_RST_BANK        8'h88
`define PDX_RST_DRIVE       2'b00
`define PDX_RST_LOADCAP     8'h00
`define PDX_RST_PUMP_FBH    5'h00
`define PDX_RST_FB_LOW      8'h00
`define PDX_RST_ODD_PRE     8'h00
`define PDX_RST_XP0         8'h00
`define PDX_RST_XP1         8'h00
`define PDX_RST_XP2         2'b00
`define PDX_RST_MULT        12'h008

`define PDX_PRE_OFFSET      8'd2
`define PDX_FB_OFFSET       11'd4

`define PDX_XP_REF          3'b000
`define PDX_XP_B1_N         3'b001
`define PDX_XP_B1_2         3'b010
`define PDX_XP_B1_3         3'b011
`define PDX_XP_B2_N         3'b100
`define PDX_XP_B2_2         3'b101
`define PDX_XP_B2_4         3'b110

`endif

/* File: inc/pdx_pkg.sv */
// Types shared by the clock generator configuration block.
// Assumes the constants header is on the include path.
`include "pdx_consts.svh"

package pdx_pkg;

   // Stored register contents; fixed bits are not held.
   typedef struct packed {
      logic [7:0] bank1;
      logic [1:0] drive;
      logic [7:0] loadcap;
      logic [4:0] pump_fbh;
      logic [7:0] fb_low;
      logic [7:0] odd_pre;
      logic [7:0] xp0;
      logic [7:0] xp1;
      logic [1:0] xp2;
      logic [7:0] bank2;
   } pdx_cfg_t;

   // Outputs of one divider bank.
   typedef struct packed {
      logic div_n;
      logic div_2;
      logic div_3;
      logic div_4;
   } pdx_bank_out_t;

   // State of one divider bank.
   typedef struct packed {
      logic [6:0]    cnt;
      logic [1:0]    ph3;
      logic [1:0]    ph4;
      logic          in_d;
      pdx_bank_out_t out;
   } pdx_bank_st_t;

   // State of the top level.
   typedef struct packed {
      pdx_cfg_t   cfg;
      logic       ref_s1;
      logic       ref_s2;
      logic       vco_s1;
      logic       vco_s2;
      logic [7:0] rdata;
      logic       rvalid;
      logic [7:0] pre_total;
      logic [11:0] mult_total;
      logic [5:0] clk_out;
   } pdx_top_st_t;

endpackage

/* File: design/pdx_top.sv */
// Configuration registers, divider banks and output crosspoint of a
// one-PLL clock generator. Registers are reached through a plain byte
// register port driven by the serial interface logic outside.
// Assumes ref_in and vco_in are clock levels from outside this domain,
// both well below half the ref_clk rate so edges can be sampled.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////
// One divider bank: counts rising edges of its input level and makes
// the /N, /2, /3 and /4 sources.
module pdx_div_bank
   import pdx_pkg::*;
(
   input  wire logic          ref_clk,
   input  wire logic          rst,
   input  wire logic          in_lvl,
   input  wire logic [6:0]    divisor,
   output pdx_bank_out_t      outs
);

   pdx_bank_st_t st_r;
   pdx_bank_st_t st_nxt;
   logic         tick;
   logic         wrap;

   // The fixed dividers restart with the /N counter so that their rising
   // edges coincide whenever the divisor is a multiple of theirs.
   always_comb begin
      st_nxt = st_r;
      tick   = in_lvl & ~st_r.in_d;
      wrap   = (st_r.cnt >= divisor - 7'd1) || (divisor < 7'd2);
      st_nxt.in_d = in_lvl;
      if (tick) begin
         if (wrap) begin
            st_nxt.cnt = 7'd0;
            st_nxt.ph3 = 2'd0;
            st_nxt.ph4 = 2'd0;
         end else begin
            st_nxt.cnt = st_r.cnt + 7'd1;
            st_nxt.ph3 = (st_r.ph3 == 2'd2) ? 2'd0 : st_r.ph3 + 2'd1;
            st_nxt.ph4 = st_r.ph4 + 2'd1;
         end
      end
      // /N high for the first half of each period, rising at count zero; /3 high one tick in three.
      st_nxt.out.div_n = st_nxt.cnt < {1'b0, divisor[6:1]};
      st_nxt.out.div_2 = ~st_nxt.ph4[0];
      st_nxt.out.div_3 = st_nxt.ph3 == 2'd0;
      st_nxt.out.div_4 = ~st_nxt.ph4[1];
   end

   // State register.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign outs = st_r.out;

endmodule

////////////////////////////////////////////////////////////////////////
// Top level: register file, source muxes, two banks and crosspoint.
module pdx_top
   import pdx_pkg::*;
(
   input  wire logic          ref_clk,
   input  wire logic          rst,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   input  wire logic [7:0]    reg_addr,
   input  wire logic [7:0]    reg_wdata,
   output logic [7:0]         reg_rdata,
   output logic               reg_rvalid,
   input  wire logic          ref_in,
   input  wire logic          vco_in,
   output logic [1:0]         drive_code,
   output logic [7:0]         load_cap_code,
   output logic [2:0]         pump_code,
   output logic [7:0]         predivide_total,
   output logic [11:0]        multiplier_total,
   output logic [5:0]         clk_out
);

   pdx_top_st_t   st_r;
   pdx_top_st_t   st_nxt;
   pdx_bank_out_t bank1_outs;
   pdx_bank_out_t bank2_outs;
   logic          bank1_input_clock;
   logic          bank2_input_clock;
   logic [9:0]    feedback_base_value;
   logic          feedback_odd_bit;
   logic [17:0]   output_source_select;
   logic [6:0]    src_lvl;
   logic [2:0]    sel;

   ////////////////////////////////////////////////////////////////////
   // Field views of the stored registers.
   assign feedback_base_value = {st_r.cfg.pump_fbh[1:0],
                                 st_r.cfg.fb_low};
   assign feedback_odd_bit    = st_r.cfg.odd_pre[`PDX_ODD_BIT];
   assign output_source_select = {st_r.cfg.xp0, st_r.cfg.xp1,
                                  st_r.cfg.xp2};

   // Each bank gets its own mux; a set select bit picks the VCO.
   assign bank1_input_clock = st_r.cfg.bank1[`PDX_SRC_BIT] ?
                              st_r.vco_s2 : st_r.ref_s2;
   assign bank2_input_clock = st_r.cfg.bank2[`PDX_SRC_BIT] ?
                              st_r.vco_s2 : st_r.ref_s2;

   // Bank 1 and bank 2 share one implementation.
   pdx_div_bank u_bank1 (
      .ref_clk (ref_clk),
      .rst     (rst),
      .in_lvl  (bank1_input_clock),
      .divisor (st_r.cfg.bank1[6:0]),
      .outs    (bank1_outs)
   );

   pdx_div_bank u_bank2 (
      .ref_clk (ref_clk),
      .rst     (rst),
      .in_lvl  (bank2_input_clock),
      .divisor (st_r.cfg.bank2[6:0]),
      .outs    (bank2_outs)
   );

   // Sources indexed by crosspoint code; index 7 is left out.
   assign src_lvl = {bank2_outs.div_4, bank2_outs.div_2, bank2_outs.div_n,
                     bank1_outs.div_3, bank1_outs.div_2, bank1_outs.div_n,
                     st_r.ref_s2};

   ////////////////////////////////////////////////////////////////////
   // Next state: synchronisers, register writes, read data, derived
   // ratios and the crosspoint. The reserved code drives a steady low
   // so a bad setting is visible rather than picking a random source.
   always_comb begin
      st_nxt = st_r;
      sel    = 3'd0;
      st_nxt.ref_s1 = ref_in;
      st_nxt.ref_s2 = st_r.ref_s1;
      st_nxt.vco_s1 = vco_in;
      st_nxt.vco_s2 = st_r.vco_s1;

      // Register writes; unmapped addresses are ignored.
      if (reg_wr) begin
         if (reg_addr == `PDX_ADDR_BANK1) begin
            st_nxt.cfg.bank1 = reg_wdata;
         end else if (reg_addr == `PDX_ADDR_DRIVE) begin
            st_nxt.cfg.drive = reg_wdata[`PDX_DRV_LSB +: 2];
         end else if (reg_addr == `PDX_ADDR_LOADCAP) begin
            st_nxt.cfg.loadcap = reg_wdata;
         end else if (reg_addr == `PDX_ADDR_PUMP_FBH) begin
            st_nxt.cfg.pump_fbh = reg_wdata[4:0];
         end else if (reg_addr == `PDX_ADDR_FB_LOW) begin
            st_nxt.cfg.fb_low = reg_wdata;
         end else if (reg_addr == `PDX_ADDR_ODD_PRE) begin
            st_nxt.cfg.odd_pre = reg_wdata;
         end else if (reg_addr == `PDX_ADDR_XP0) begin
            st_nxt.cfg.xp0 = reg_wdata;
         end else if (reg_addr == `PDX_ADDR_XP1) begin
            st_nxt.cfg.xp1 = reg_wdata;
         end else if (reg_addr == `PDX_ADDR_XP2) begin
            // Low six bits are fixed and any value written is dropped.
            st_nxt.cfg.xp2 = reg_wdata[`PDX_XP2_LSB +: 2];
         end else if (reg_addr == `PDX_ADDR_BANK2) begin
            st_nxt.cfg.bank2 = reg_wdata;
         end
      end

      // Register reads answer one cycle later; unmapped reads give zero.
      st_nxt.rvalid = reg_rd;
      if (reg_rd) begin
         if (reg_addr == `PDX_ADDR_BANK1) begin
            st_nxt.rdata = st_r.cfg.bank1;
         end else if (reg_addr == `PDX_ADDR_DRIVE) begin
            st_nxt.rdata = {`PDX_R12_HIGH, st_r.cfg.drive, `PDX_R12_LOW};
         end else if (reg_addr == `PDX_ADDR_LOADCAP) begin
            st_nxt.rdata = st_r.cfg.loadcap;
         end else if (reg_addr == `PDX_ADDR_PUMP_FBH) begin
            st_nxt.rdata = {`PDX_R40_FIXED, st_r.cfg.pump_fbh};
         end else if (reg_addr == `PDX_ADDR_FB_LOW) begin
            st_nxt.rdata = st_r.cfg.fb_low;
         end else if (reg_addr == `PDX_ADDR_ODD_PRE) begin
            st_nxt.rdata = st_r.cfg.odd_pre;
         end else if (reg_addr == `PDX_ADDR_XP0) begin
            st_nxt.rdata = st_r.cfg.xp0;
         end else if (reg_addr == `PDX_ADDR_XP1) begin
            st_nxt.rdata = st_r.cfg.xp1;
         end else if (reg_addr == `PDX_ADDR_XP2) begin
            st_nxt.rdata = {st_r.cfg.xp2, `PDX_R46_FIXED};
         end else if (reg_addr == `PDX_ADDR_BANK2) begin
            st_nxt.rdata = st_r.cfg.bank2;
         end else begin
            st_nxt.rdata = 8'h00;
         end
      end

      // Ratios handed to the analog loop: VCO = ref / pre * mult.
      st_nxt.pre_total = {1'b0, st_r.cfg.odd_pre[6:0]}
                         + `PDX_PRE_OFFSET;
      st_nxt.mult_total = {{1'b0, feedback_base_value} + `PDX_FB_OFFSET,
                           feedback_odd_bit};

      // Crosspoint: first field drives output 0.
      for (int i = 0; i < 6; i++) begin
         sel = output_source_select[17 - 3*i -: 3];
         st_nxt.clk_out[i] = (sel == 3'b111) ? 1'b0
                                             : src_lvl[sel];
      end
   end

   ////////////////////////////////////////////////////////////////////
   // State register; reset brings back the default contents, as after
   // a power cycle, since nothing here is kept across it.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_r             <= '0;
         st_r.cfg.bank1   <= `PDX_RST_BANK;
         st_r.cfg.drive   <= `PDX_RST_DRIVE;
         st_r.cfg.loadcap <= `PDX_RST_LOADCAP;
         st_r.cfg.pump_fbh <= `PDX_RST_PUMP_FBH;
         st_r.cfg.fb_low  <= `PDX_RST_FB_LOW;
         st_r.cfg.odd_pre <= `PDX_RST_ODD_PRE;
         st_r.cfg.xp0     <= `PDX_RST_XP0;
         st_r.cfg.xp1     <= `PDX_RST_XP1;
         st_r.cfg.xp2     <= `PDX_RST_XP2;
         st_r.cfg.bank2   <= `PDX_RST_BANK;
         st_r.pre_total   <= `PDX_PRE_OFFSET;
         st_r.mult_total  <= `PDX_RST_MULT;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register.
   assign reg_rdata        = st_r.rdata;
   assign reg_rvalid       = st_r.rvalid;
   assign drive_code       = st_r.cfg.drive;
   assign load_cap_code    = st_r.cfg.loadcap;
   assign pump_code        = st_r.cfg.pump_fbh[4:2];
   assign predivide_total  = st_r.pre_total;
   assign multiplier_total = st_r.mult_total;
   assign clk_out          = st_r.clk_out;

endmodule

/* File: tb/pdx_top_properties.sv */
// Checker for the configuration block: register port and PLL totals.
// Assumes it is bound to pdx_top and sees only that module's ports.
`timescale 1ns/1ps

module pdx_top_properties
   import pdx_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [7:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic [7:0]  reg_rdata,
   input wire logic        reg_rvalid,
   input wire logic [7:0]  load_cap_code,
   input wire logic [7:0]  predivide_total,
   input wire logic [11:0] multiplier_total,
   input wire logic [5:0]  clk_out
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////
   // Totals follow a write two edges later, carrying the stored value.
   property p_pre;
      logic [7:0] v;
      (reg_wr && reg_addr == 8'h42, v = reg_wdata)
         |-> ##2 predivide_total == {1'b0, v[6:0]} + 8'h02;
   endproperty
   a_pre: assert property (p_pre) else $error("predivide wrong");
   property p_odd;
      logic [7:0] v;
      (reg_wr && reg_addr == 8'h42, v = reg_wdata)
         |-> ##2 multiplier_total[0] == v[7];
   endproperty
   a_odd: assert property (p_odd) else $error("odd bit wrong");
   property p_low;
      logic [7:0] v;
      (reg_wr && reg_addr == 8'h41, v = reg_wdata)
         |-> ##2 multiplier_total[8:1] == v + 8'h04;
   endproperty
   a_low: assert property (p_low) else $error("base low wrong");
   property p_cap;
      logic [7:0] v;
      (reg_wr && reg_addr == 8'h13, v = reg_wdata)
         |-> ##2 load_cap_code == v;
   endproperty
   a_cap: assert property (p_cap) else $error("load cap wrong");

   ////////////////////////////////////////////////////////////////////
   // Fixed bits, reset contents and the read answer.
   property p_r40;
      (reg_rd && reg_addr == 8'h40) |=> reg_rdata[7:5] == 3'b110;
   endproperty
   a_r40: assert property (p_r40) else $error("pump reg top bits");
   property p_r46;
      (reg_rd && reg_addr == 8'h46) |=> reg_rdata[5:0] == 6'h3F;
   endproperty
   a_r46: assert property (p_r46) else $error("46H low bits");
   property p_rst;
      $fell(rst) |-> predivide_total == 8'h02 && multiplier_total == 12'h008
         && load_cap_code == 8'h00 && clk_out == 6'h00;
   endproperty
   a_rst: assert property (p_rst) else $error("reset contents");
   property p_range;
      predivide_total inside {[8'h02:8'h81]}
         && multiplier_total inside {[12'h008:12'h807]};
   endproperty
   a_range: assert property (p_range) else $error("total range");
   property p_rv;
      reg_rvalid == $past(reg_rd) && (!$past(reg_rd) -> $stable(reg_rdata));
   endproperty
   a_rv: assert property (p_rv) else $error("read answer timing");
endmodule

bind pdx_top pdx_top_properties i_props (
   .ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .reg_rvalid(reg_rvalid), .load_cap_code(load_cap_code),
   .predivide_total(predivide_total), .multiplier_total(multiplier_total),
   .clk_out(clk_out)
);

/* File: tb/pdx_host_model.sv */
// Host that programs the block through its byte register port.
// Assumes requests are taken on the rising edge of ref_clk.
`timescale 1ns/1ps

module pdx_host_model (
   input  wire logic       ref_clk,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid,
   output logic            reg_wr,
   output logic            reg_rd,
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wdata
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end

   // Released address and data are inverted so stale values never match.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #2;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge ref_clk);
      #2;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask

   // The answer is taken one cycle after the request edge.
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
                     output logic v);
      @(posedge ref_clk);
      #2;
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge ref_clk);
      #2;
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
      v = reg_rvalid;
   endtask

   // Crosspoint fields; 46H low bits always go out with their fixed ones.
   task automatic xp(input logic [17:0] x);
      wr(8'h44, x[17:10]);
      wr(8'h45, x[9:2]);
      wr(8'h46, {x[1:0], 6'h3F});
   endtask

   // Pump code is chosen from the multiplier total it goes with.
   task automatic pll(input logic [9:0] base, input logic odd,
                      input logic [6:0] q);
      int p;
      logic [2:0] c;
      p = 2 * (base + 4) + odd;
      c = p < 45 ? 3'h0 : p < 480 ? 3'h1 : p < 640 ? 3'h2 :
          p < 800 ? 3'h3 : 3'h4;
      wr(8'h40, {3'b110, c, base[9:8]});
      wr(8'h41, base[7:0]);
      wr(8'h42, {odd, q});
   endtask
endmodule

/* File: tb/test_pll_divider_crosspoint_config.sv */
// Testbench for the configuration block: registers, totals, dividers.
// Assumes the host model and the bound checker are compiled before it.
`timescale 1ns/1ps

module test_pll_divider_crosspoint_config;
   import pdx_pkg::*;
   logic ref_clk = 1'b0, rst = 1'b1, ref_in = 1'b0, vco_in = 1'b0;
   logic reg_wr, reg_rd, reg_rvalid;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, load_cap_code, pre_t;
   logic [1:0] drive_code;
   logic [2:0] pump_code;
   logic [11:0] mult_t;
   logic [5:0] clk_out;
   int bad_count = 0, n_checks = 0, cyc = 0;

   always #12.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) cyc++;
   // Reference has period 8 cycles, VCO period 6 cycles.
   initial forever begin
      repeat (4) @(posedge ref_clk);
      #2;
      ref_in = ~ref_in;
   end
   initial forever begin
      repeat (3) @(posedge ref_clk);
      #2;
      vco_in = ~vco_in;
   end

   pdx_host_model i_host (.ref_clk(ref_clk), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata));
   pdx_top i_dut (.ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .ref_in(ref_in),
      .vco_in(vco_in), .drive_code(drive_code),
      .load_cap_code(load_cap_code), .pump_code(pump_code),
      .predivide_total(pre_t), .multiplier_total(mult_t),
      .clk_out(clk_out));

   ////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [11:0] e,
                      input logic [11:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic v;
      i_host.rd(a, d, v);
      cmp("rvalid", 12'h001, {11'h000, v});
      cmp("rdata", {4'h0, e}, {4'h0, d});
   endtask
   // Bounded wait for a rising level on one output.
   task automatic wait_rise(input int b);
      logic p;
      p = clk_out[b];
      repeat (400) begin
         @(posedge ref_clk);
         #2;
         if (clk_out[b] === 1'b1 && p === 1'b0) return;
         p = clk_out[b];
      end
      cmp("rise timeout", 12'h001, 12'h000);
      end_of_test();
   endtask
   task automatic period(input int b, input logic [11:0] e);
      int t0;
      wait_rise(b);
      t0 = cyc;
      wait_rise(b);
      cmp("period", e, 12'(cyc - t0));
   endtask
   // Every rise of output a must land on a rise of output b; with rsv
   // set, output 2 carries the reserved code and must stay low.
   task automatic align(input int a, input int b, input bit rsv);
      logic [5:0] p;
      p = clk_out;
      repeat (200) begin
         @(posedge ref_clk);
         #2;
         if (clk_out[a] && !p[a])
            cmp("aligned rise", 12'h001, {11'h000, clk_out[b] & ~p[b]});
         if (rsv) cmp("reserved low", 12'h000, {11'h000, clk_out[2]});
         p = clk_out;
      end
   endtask

   ////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      rdchk(8'h0C, 8'h88);
      rdchk(8'h13, 8'h00);
      rdchk(8'h40, 8'hC0);
      rdchk(8'h42, 8'h00);
      rdchk(8'h46, 8'h3F);
      rdchk(8'h47, 8'h88);
      cmp("predivide", 12'h002, {4'h0, pre_t});
      cmp("multiplier", 12'h008, mult_t);
   endtask
   task automatic t_regs();
      i_host.wr(8'h40, 8'hF0);
      rdchk(8'h40, 8'hD0);
      cmp("pump", 12'h004, {9'h000, pump_code});
      i_host.wr(8'h12, 8'hE7);
      cmp("drive", 12'h000, {10'h000, drive_code});
      rdchk(8'h12, 8'h20);
      i_host.wr(8'h13, 8'hA5);
      cmp("load cap", 12'h0A5, {4'h0, load_cap_code});
      i_host.wr(8'h43, 8'h55);
      rdchk(8'h43, 8'h00);
   endtask
   task automatic t_pll(input logic [9:0] base, input logic odd,
                        input logic [6:0] q, input logic [11:0] em);
      i_host.pll(base, odd, q);
      @(posedge ref_clk);
      #2;
      cmp("multiplier", em, mult_t);
      cmp("predivide", {5'h00, q} + 12'h002, {4'h0, pre_t});
   endtask
   task automatic t_div();
      i_host.wr(8'h0C, 8'h08);
      i_host.wr(8'h47, 8'h88);
      i_host.xp({3'h1, 3'h2, 3'h0, 3'h4, 3'h5, 3'h6});
      repeat (150) @(posedge ref_clk);
      period(0, 12'd64);
      period(1, 12'd16);
      period(2, 12'd8);
      period(3, 12'd48);
      period(4, 12'd12);
      period(5, 12'd24);
      align(3, 4, 1'b0);
      align(3, 5, 1'b0);
      align(0, 1, 1'b0);
      i_host.wr(8'h0C, 8'h86);
      i_host.xp({3'h1, 3'h3, 3'h7, 3'h4, 3'h5, 3'h6});
      repeat (150) @(posedge ref_clk);
      period(0, 12'd36);
      period(1, 12'd18);
      align(0, 1, 1'b1);
   endtask

   initial begin
      repeat (5) @(posedge ref_clk);
      #2;
      rst = 1'b0;
      t_reset();
      t_regs();
      t_pll(10'h3FF, 1'b1, 7'h7F, 12'h807);
      t_pll(10'h064, 1'b1, 7'h05, 12'h0D1);
      t_div();
      @(posedge ref_clk);
      #2;
      rst = 1'b1;
      repeat (5) @(posedge ref_clk);
      #2;
      rst = 1'b0;
      t_reset();
      end_of_test();
   end
endmodule
